// *** include/ifsb_cfg.svh ***
// Offsets, field positions, implemented-bit masks and reset values of the flag bank
`ifndef IFSB_CFG_SVH
`define IFSB_CFG_SVH

`define IFSB_OFF_WORD1   4'h0
`define IFSB_OFF_WORD2   4'h1
`define IFSB_OFF_WORD3   4'h2
`define IFSB_OFF_WORD4   4'h3
`define IFSB_OFF_STATUS  4'h4
`define IFSB_OFF_MASK    4'h5

`define IFSB_IMPL_WORD1  16'h0007
`define IFSB_IMPL_WORD2  16'h6ff3
`define IFSB_IMPL_WORD3  16'h6066
`define IFSB_IMPL_WORD4  16'h210e

`define IFSB_FLAG_RST    16'h0000
`define IFSB_RDATA_RST   16'h0000
`define IFSB_IRQ_RST     4'h0

`define IFSB_B1_CMP      2
`define IFSB_B1_TW1M     1
`define IFSB_B1_TW1S     0
`define IFSB_B2_DMA4     14
`define IFSB_B2_PPORT    13
`define IFSB_B2_OC7      11
`define IFSB_B2_OC6      10
`define IFSB_B2_OC5      9
`define IFSB_B2_IC6      8
`define IFSB_B2_IC5      7
`define IFSB_B2_IC4      6
`define IFSB_B2_IC3      5
`define IFSB_B2_DMA3     4
`define IFSB_B2_SP2EV    1
`define IFSB_B2_SP2FT    0
`define IFSB_B3_CAL      14
`define IFSB_B3_DMA5     13
`define IFSB_B3_PIN4     6
`define IFSB_B3_PIN3     5
`define IFSB_B3_TW2M     2
`define IFSB_B3_TW2S     1
`define IFSB_B4_CTU      13
`define IFSB_B4_LVD      8
`define IFSB_B4_CRC      3
`define IFSB_B4_SER2     2
`define IFSB_B4_SER1     1

`define IFSB_ST_WORD1    0
`define IFSB_ST_WORD2    1
`define IFSB_ST_WORD3    2
`define IFSB_ST_WORD4    3

`endif

// *** include/ifsb_pkg.sv ***
// Types shared by the flag bank: words, event bundle and flag snapshot
package ifsb_pkg;

	typedef logic [15:0] ifsb_word_t;
	typedef logic [3:0]  ifsb_irq_t;

	typedef struct packed {
		logic comparator_request_flag;
		logic twowire1_master_flag;
		logic twowire1_slave_flag;
		logic dma_chan4_flag;
		logic parallel_port_flag;
		logic out_compare7_flag;
		logic out_compare6_flag;
		logic out_compare5_flag;
		logic in_capture6_flag;
		logic in_capture5_flag;
		logic in_capture4_flag;
		logic in_capture3_flag;
		logic dma_chan3_flag;
		logic serial_periph2_event_flag;
		logic serial_periph2_fault_flag;
		logic calendar_clock_flag;
		logic dma_chan5_flag;
		logic ext_pin4_flag;
		logic ext_pin3_flag;
		logic twowire2_master_flag;
		logic twowire2_slave_flag;
		logic charge_time_unit_flag;
		logic low_voltage_flag;
		logic checksum_gen_flag;
		logic serial_port2_error_flag;
		logic serial_port1_error_flag;
	} ifsb_events_s;

	typedef struct packed {
		ifsb_word_t word4;
		ifsb_word_t word3;
		ifsb_word_t word2;
		ifsb_word_t word1;
	} ifsb_flags_s;

endpackage

// *** core/ifsb_bank.sv ***
// Sticky interrupt flag bank with register port, event status, mask and interrupt
// Function
// - Flags show requests; software reads and writes
// - All flags cleared after reset
// - Unassigned bits read zero, ignore writes
// - Word1 bits 2..0: comparator, two-wire1 master/slave
// - Word2 bit14 DMA4, bit13 parallel port
// - Word2 bits 11..9: output compare 7..5
// - Word2 bits 8..5: input capture 6..3
// - Word2 bit4 DMA3, bits1..0 serial periph2
// - Word3 bit14 calendar clock, bit13 DMA5
// - Word3 bit6 pin4, bit5 pin3
// - Word3 bits 2..1 two-wire2 master/slave
// - Word4 bit13 charge time, bit8 low voltage
// - Word4 bit3 checksum, bits2..1 serial errors
`include "ifsb_cfg.svh"

module ifsb_bank
	import ifsb_pkg::*;
#(
	parameter int ADDR_W = 4
)
(
	input  wire logic              clock_in,
	input  wire logic              reset_n_in,
	input  wire ifsb_events_s      events_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire ifsb_word_t        wr_data_in,
	input  wire logic              wr_en_in,
	input  wire logic              rd_en_in,
	output ifsb_word_t             rd_data_out,
	output ifsb_flags_s            flags_out,
	output logic                   irq_out
);

	// Offsets up to the mask register need three address bits
	if (ADDR_W < 3)
	begin : g_addr_check
		$error("ifsb_bank: ADDR_W must be at least 3");
	end

	ifsb_word_t  word1_ff;
	ifsb_word_t  word2_ff;
	ifsb_word_t  word3_ff;
	ifsb_word_t  word4_ff;
	ifsb_word_t  nxt_word1;
	ifsb_word_t  nxt_word2;
	ifsb_word_t  nxt_word3;
	ifsb_word_t  nxt_word4;
	ifsb_word_t  set1;
	ifsb_word_t  set2;
	ifsb_word_t  set3;
	ifsb_word_t  set4;
	ifsb_irq_t   status_ff;
	ifsb_irq_t   nxt_status;
	ifsb_irq_t   status_set;
	ifsb_irq_t   mask_ff;
	ifsb_word_t  rd_data_ff;
	ifsb_word_t  nxt_rd_data;
	logic        irq_ff;

	function automatic logic addr_hit(logic [ADDR_W-1:0] a, logic [3:0] off);
		return a == ADDR_W'(off);
	endfunction

	// Keeps a word, takes a write, then merges events over it
	function automatic ifsb_word_t flag_next(ifsb_word_t cur, logic wr, ifsb_word_t wd,
		ifsb_word_t set, ifsb_word_t impl);
		ifsb_word_t base;
		base = wr ? wd : cur;
		return (base | set) & impl;
	endfunction

	function automatic ifsb_word_t map_word1(ifsb_events_s ev);
		ifsb_word_t v;
		v = `IFSB_FLAG_RST;
		v[`IFSB_B1_CMP]  = ev.comparator_request_flag;
		v[`IFSB_B1_TW1M] = ev.twowire1_master_flag;
		v[`IFSB_B1_TW1S] = ev.twowire1_slave_flag;
		return v;
	endfunction

	function automatic ifsb_word_t map_word2(ifsb_events_s ev);
		ifsb_word_t v;
		v = `IFSB_FLAG_RST;
		v[`IFSB_B2_DMA4]  = ev.dma_chan4_flag;
		v[`IFSB_B2_PPORT] = ev.parallel_port_flag;
		v[`IFSB_B2_OC7]   = ev.out_compare7_flag;
		v[`IFSB_B2_OC6]   = ev.out_compare6_flag;
		v[`IFSB_B2_OC5]   = ev.out_compare5_flag;
		v[`IFSB_B2_IC6]   = ev.in_capture6_flag;
		v[`IFSB_B2_IC5]   = ev.in_capture5_flag;
		v[`IFSB_B2_IC4]   = ev.in_capture4_flag;
		v[`IFSB_B2_IC3]   = ev.in_capture3_flag;
		v[`IFSB_B2_DMA3]  = ev.dma_chan3_flag;
		v[`IFSB_B2_SP2EV] = ev.serial_periph2_event_flag;
		v[`IFSB_B2_SP2FT] = ev.serial_periph2_fault_flag;
		return v;
	endfunction

	function automatic ifsb_word_t map_word3(ifsb_events_s ev);
		ifsb_word_t v;
		v = `IFSB_FLAG_RST;
		v[`IFSB_B3_CAL]  = ev.calendar_clock_flag;
		v[`IFSB_B3_DMA5] = ev.dma_chan5_flag;
		v[`IFSB_B3_PIN4] = ev.ext_pin4_flag;
		v[`IFSB_B3_PIN3] = ev.ext_pin3_flag;
		v[`IFSB_B3_TW2M] = ev.twowire2_master_flag;
		v[`IFSB_B3_TW2S] = ev.twowire2_slave_flag;
		return v;
	endfunction

	function automatic ifsb_word_t map_word4(ifsb_events_s ev);
		ifsb_word_t v;
		v = `IFSB_FLAG_RST;
		v[`IFSB_B4_CTU]  = ev.charge_time_unit_flag;
		v[`IFSB_B4_LVD]  = ev.low_voltage_flag;
		v[`IFSB_B4_CRC]  = ev.checksum_gen_flag;
		v[`IFSB_B4_SER2] = ev.serial_port2_error_flag;
		v[`IFSB_B4_SER1] = ev.serial_port1_error_flag;
		return v;
	endfunction

	always_comb
	begin
		set1 = map_word1(events_in);
		set2 = map_word2(events_in);
		set3 = map_word3(events_in);
		set4 = map_word4(events_in);
	end

	always_comb
	begin
		nxt_word1 = flag_next(word1_ff, wr_en_in && addr_hit(addr_in, `IFSB_OFF_WORD1),
			wr_data_in, set1, `IFSB_IMPL_WORD1);
		nxt_word2 = flag_next(word2_ff, wr_en_in && addr_hit(addr_in, `IFSB_OFF_WORD2),
			wr_data_in, set2, `IFSB_IMPL_WORD2);
		nxt_word3 = flag_next(word3_ff, wr_en_in && addr_hit(addr_in, `IFSB_OFF_WORD3),
			wr_data_in, set3, `IFSB_IMPL_WORD3);
		nxt_word4 = flag_next(word4_ff, wr_en_in && addr_hit(addr_in, `IFSB_OFF_WORD4),
			wr_data_in, set4, `IFSB_IMPL_WORD4);
	end

	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
			word1_ff <= `IFSB_FLAG_RST;
		else
			word1_ff <= nxt_word1;
	end

	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
			word2_ff <= `IFSB_FLAG_RST;
		else
			word2_ff <= nxt_word2;
	end

	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
			word3_ff <= `IFSB_FLAG_RST;
		else
			word3_ff <= nxt_word3;
	end

	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
			word4_ff <= `IFSB_FLAG_RST;
		else
			word4_ff <= nxt_word4;
	end

	// Event status: one sticky bit per word, read clears, set wins
	always_comb
	begin
		status_set = `IFSB_IRQ_RST;
		status_set[`IFSB_ST_WORD1] = |(set1 & `IFSB_IMPL_WORD1);
		status_set[`IFSB_ST_WORD2] = |(set2 & `IFSB_IMPL_WORD2);
		status_set[`IFSB_ST_WORD3] = |(set3 & `IFSB_IMPL_WORD3);
		status_set[`IFSB_ST_WORD4] = |(set4 & `IFSB_IMPL_WORD4);
		if (rd_en_in && addr_hit(addr_in, `IFSB_OFF_STATUS))
			nxt_status = status_set;
		else
			nxt_status = status_ff | status_set;
	end

	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
			status_ff <= `IFSB_IRQ_RST;
		else
			status_ff <= nxt_status;
	end

	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
			mask_ff <= `IFSB_IRQ_RST;
		else if (wr_en_in && addr_hit(addr_in, `IFSB_OFF_MASK))
			mask_ff <= wr_data_in[$bits(ifsb_irq_t)-1:0];
	end

	// Follows next status so the level lines up with the status register
	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
			irq_ff <= 1'b0;
		else if (wr_en_in && addr_hit(addr_in, `IFSB_OFF_MASK))
			irq_ff <= |(nxt_status & wr_data_in[$bits(ifsb_irq_t)-1:0]);
		else
			irq_ff <= |(nxt_status & mask_ff);
	end

	// read mux, unused bits and addresses read zero
	always_comb
	begin
		nxt_rd_data = `IFSB_RDATA_RST;
		if (rd_en_in)
		begin
			case (addr_in)
				ADDR_W'(`IFSB_OFF_WORD1):  nxt_rd_data = word1_ff;
				ADDR_W'(`IFSB_OFF_WORD2):  nxt_rd_data = word2_ff;
				ADDR_W'(`IFSB_OFF_WORD3):  nxt_rd_data = word3_ff;
				ADDR_W'(`IFSB_OFF_WORD4):  nxt_rd_data = word4_ff;
				ADDR_W'(`IFSB_OFF_STATUS): nxt_rd_data = {12'h000, status_ff};
				ADDR_W'(`IFSB_OFF_MASK):   nxt_rd_data = {12'h000, mask_ff};
				default:                   nxt_rd_data = `IFSB_RDATA_RST;
			endcase
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
			rd_data_ff <= `IFSB_RDATA_RST;
		else
			rd_data_ff <= nxt_rd_data;
	end

	assign rd_data_out = rd_data_ff;
	assign irq_out     = irq_ff;
	assign flags_out   = '{word4: word4_ff, word3: word3_ff, word2: word2_ff, word1: word1_ff};

	a_reset_clears: assert property (@(posedge clock_in)
		!reset_n_in |=> (word1_ff == 16'h0000 && word2_ff == 16'h0000 &&
			word3_ff == 16'h0000 && word4_ff == 16'h0000))
		else $error("flags not cleared by reset");

	a_unimpl_zero: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		((word1_ff & ~16'h0007) == 16'h0000) && ((word2_ff & ~16'h6ff3) == 16'h0000) &&
		((word3_ff & ~16'h6066) == 16'h0000) && ((word4_ff & ~16'h210e) == 16'h0000))
		else $error("unimplemented flag bit set");

	a_write_store: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(wr_en_in && addr_in == ADDR_W'(4'h1) && map_word2(events_in) == 16'h0000)
		|=> word2_ff == ($past(wr_data_in) & 16'h6ff3))
		else $error("word2 write not stored");

	a_read_word3: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(rd_en_in && addr_in == ADDR_W'(4'h2)) |=> rd_data_out == $past(word3_ff))
		else $error("word3 read data wrong");

	a_cmp_set_wins: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(events_in.comparator_request_flag && wr_en_in && addr_in == ADDR_W'(4'h0) &&
		!wr_data_in[2]) |=> word1_ff[2])
		else $error("comparator event lost to clear");

	a_flag_holds: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(word4_ff[8] && !(wr_en_in && addr_in == ADDR_W'(4'h3))) |=> word4_ff[8])
		else $error("low voltage flag dropped without write");

	a_tw1_slave: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.twowire1_slave_flag |=> word1_ff[0] && $past(events_in.twowire1_slave_flag))
		else $error("two-wire1 slave flag not set");

	a_dma4_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.dma_chan4_flag |=> word2_ff[14])
		else $error("dma4 flag not set");

	a_oc_order: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(events_in.out_compare7_flag && !events_in.out_compare5_flag && !word2_ff[9] &&
		!wr_en_in) |=> (word2_ff[11] && !word2_ff[9]))
		else $error("output compare bits misplaced");

	a_ic3_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.in_capture3_flag |=> word2_ff[5])
		else $error("input capture3 flag not set");

	a_sp2_fault: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.serial_periph2_fault_flag |=> word2_ff[0])
		else $error("serial periph2 fault flag not set");

	a_cal_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.calendar_clock_flag |=> word3_ff[14])
		else $error("calendar flag not set");

	a_pin4_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.ext_pin4_flag |=> word3_ff[6])
		else $error("pin4 flag not set");

	a_tw2_master: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.twowire2_master_flag |=> word3_ff[2] && !word3_ff[0])
		else $error("two-wire2 master flag wrong");

	a_ctu_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.charge_time_unit_flag |=> word4_ff[13])
		else $error("charge time flag not set");

	a_crc_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.checksum_gen_flag |=> word4_ff[3])
		else $error("checksum flag not set");

	a_tw1_master: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.twowire1_master_flag |=> word1_ff[`IFSB_B1_TW1M])
		else $error("two-wire1 master flag not set");

	a_pport_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.parallel_port_flag |=> word2_ff[`IFSB_B2_PPORT])
		else $error("parallel port flag not set");

	a_oc6_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.out_compare6_flag |=> word2_ff[`IFSB_B2_OC6])
		else $error("output compare6 flag not set");

	a_ic6_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.in_capture6_flag |=> word2_ff[`IFSB_B2_IC6])
		else $error("input capture6 flag not set");

	a_dma3_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.dma_chan3_flag |=> word2_ff[`IFSB_B2_DMA3])
		else $error("dma3 flag not set");

	a_sp2_event: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.serial_periph2_event_flag |=> word2_ff[`IFSB_B2_SP2EV])
		else $error("serial periph2 event flag not set");

	a_dma5_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.dma_chan5_flag |=> word3_ff[`IFSB_B3_DMA5])
		else $error("dma5 flag not set");

	a_pin3_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.ext_pin3_flag |=> word3_ff[`IFSB_B3_PIN3])
		else $error("pin3 flag not set");

	a_tw2_slave: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.twowire2_slave_flag |=> word3_ff[`IFSB_B3_TW2S])
		else $error("two-wire2 slave flag not set");

	a_lvd_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.low_voltage_flag |=> word4_ff[`IFSB_B4_LVD])
		else $error("low voltage flag not set");

	a_ser2_error: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.serial_port2_error_flag |=> word4_ff[`IFSB_B4_SER2])
		else $error("serial port2 error flag not set");

	a_ser1_error: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		events_in.serial_port1_error_flag |=> word4_ff[`IFSB_B4_SER1])
		else $error("serial port1 error flag not set");

	a_status_sticky: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(events_in.dma_chan4_flag && rd_en_in && addr_in == ADDR_W'(`IFSB_OFF_STATUS))
		|=> status_ff[`IFSB_ST_WORD2])
		else $error("status event lost to clearing read");

	a_read_idle: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		!rd_en_in |=> rd_data_out == `IFSB_RDATA_RST)
		else $error("read data not zero outside read cycle");

	a_unmapped_read: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(rd_en_in && addr_in > ADDR_W'(`IFSB_OFF_MASK)) |=> rd_data_out == `IFSB_RDATA_RST)
		else $error("unmapped address read not zero");

	a_irq_level: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		##1 irq_out == |(status_ff & mask_ff))
		else $error("irq level disagrees with status and mask");

endmodule // ifsb_bank

// *** dv/ifsb_evsrc.sv ***
// Model of the on-chip peripheral event sources that feed the flag bank
module ifsb_evsrc
	import ifsb_pkg::*;
(
	output ifsb_events_s events_out
);
	timeunit 1ns;
	timeprecision 100ps;

	initial events_out = '0;

	task automatic pulse(input int idx, ref logic clk);
		@(posedge clk);
		events_out <= ifsb_events_s'(26'h1 << idx);
		@(posedge clk);
		events_out <= '0;
	endtask
endmodule // ifsb_evsrc

// *** dv/tb.sv ***
// Self-checking bench for the interrupt flag bank
module tb
	import ifsb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic         clock_in;
	logic         reset_n_in;
	logic         wr_en_in;
	logic         rd_en_in;
	logic         irq_out;
	logic [3:0]   addr_in;
	ifsb_word_t   wr_data_in;
	ifsb_word_t   rd_data_out;
	ifsb_word_t   d;
	ifsb_events_s events_in;
	ifsb_flags_s  flags_out;
	int           n_mismatch;
	int           checks;
	int           cyc;
	// Flag position in flags_out for each event field, LSB field first
	int pos [26] = '{49, 50, 51, 56, 61, 33, 34, 37, 38, 45, 46, 16, 17, 20, 21, 22, 23,
		24, 25, 26, 27, 29, 30, 0, 1, 2};
	ifsb_word_t impl [4] = '{16'h0007, 16'h6ff3, 16'h6066, 16'h210e};

	ifsb_bank #(.ADDR_W(4)) u_ifsb_bank (
		.clock_in(clock_in), .reset_n_in(reset_n_in), .events_in(events_in),
		.addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
		.rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .flags_out(flags_out),
		.irq_out(irq_out));

	ifsb_evsrc u_ifsb_evsrc (.events_out(events_in));

	initial
	begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end

	always @(posedge clock_in)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input ifsb_word_t v);
		@(posedge clock_in);
		addr_in <= a;
		wr_data_in <= v;
		wr_en_in <= 1'b1;
		@(posedge clock_in);
		wr_en_in <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, output ifsb_word_t v);
		@(posedge clock_in);
		addr_in <= a;
		rd_en_in <= 1'b1;
		@(posedge clock_in);
		rd_en_in <= 1'b0;
		#1;
		v = rd_data_out;
	endtask

	task automatic pulse(input int idx);
		u_ifsb_evsrc.pulse(idx, clock_in);
		#1;
	endtask

	task automatic t_reset();
		for (int a = 0; a < 6; a++)
		begin
			rd(a[3:0], d);
			chk(d, 0);
		end
		chk(flags_out, 0);
		chk(irq_out, 0);
	endtask

	task automatic t_access();
		for (int a = 0; a < 4; a++)
		begin
			wr(a[3:0], 16'hffff);
			rd(a[3:0], d);
			chk(d, impl[a]);
			wr(a[3:0], 16'h0000);
			rd(a[3:0], d);
			chk(d, 0);
		end
		rd(4'h4, d);
		chk(d, 0);
		wr(4'h6, 16'hffff);
		rd(4'h6, d);
		chk(d, 0);
		@(posedge clock_in);
		#1;
		chk(rd_data_out, 0);
	endtask

	task automatic t_events();
		for (int i = 0; i < 26; i++)
		begin
			pulse(i);
			chk(flags_out, 64'h1 << pos[i]);
			rd(4'(pos[i] / 16), d);
			chk(d, 16'h1 << (pos[i] % 16));
			rd(4'h4, d);
			chk(d, 16'h1 << (pos[i] / 16));
			wr(4'(pos[i] / 16), 16'h0000);
			chk(flags_out, 0);
		end
	endtask

	task automatic t_race();
		pulse(20);
		fork
			wr(4'h1, 16'h0000);
			u_ifsb_evsrc.pulse(22, clock_in);
		join
		chk(flags_out, 64'h4000_0000);
		rd(4'h1, d);
		wr(4'h1, d & ~16'h4000);
		chk(flags_out, 0);
		rd(4'h4, d);
		chk(d, 16'h0002);
	endtask

	task automatic t_irq();
		wr(4'h5, 16'h0002);
		pulse(22);
		chk(irq_out, 1);
		rd(4'h4, d);
		chk(d, 16'h0002);
		chk(irq_out, 0);
		pulse(0);
		chk(irq_out, 0);
		wr(4'h5, 16'h000a);
		chk(irq_out, 1);
		rd(4'h4, d);
		chk(d, 16'h0008);
		chk(irq_out, 0);
		rd(4'h5, d);
		chk(d, 16'h000a);
		wr(4'h5, 16'h0000);
		wr(4'h1, 16'h0000);
		wr(4'h3, 16'h0000);
		chk(flags_out, 0);
	endtask

	task automatic t_midreset();
		wr(4'h5, 16'h0001);
		pulse(25);
		chk(irq_out, 1);
		@(posedge clock_in);
		reset_n_in <= 1'b0;
		@(posedge clock_in);
		reset_n_in <= 1'b1;
		#1;
		chk(flags_out, 0);
		chk(irq_out, 0);
		rd(4'h4, d);
		chk(d, 0);
		rd(4'h5, d);
		chk(d, 0);
	endtask

	initial
	begin
		reset_n_in = 1'b0;
		wr_en_in = 1'b0;
		rd_en_in = 1'b0;
		addr_in = 4'h0;
		wr_data_in = 16'h0000;
		n_mismatch = 0;
		checks = 0;
		cyc = 0;
		repeat (12) @(posedge clock_in);
		reset_n_in <= 1'b1;
		t_reset();
		t_access();
		t_events();
		t_race();
		t_irq();
		t_midreset();
		report_and_stop();
	end
endmodule // tb
